// file: rtl/iec_interrupt_enable_control.sv
// Interrupt enable, flag and request logic behind an Avalon-MM slave
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Register map: byte offsets on the bus, register data in bits 7:0
// Upper read data bits are always zero; unmapped reads return zero
//
// 0x00 interrupt_control, reset 0x00
//   bit 7 global_irq_gate: master gate over every request
//   bit 6 peripheral_irq_gate: gate over all peripheral pairs
//   bit 5 timer_zero_overflow_enable: enables the rollover request
//   bit 4 external pin enable: enables the external edge request
//   bit 3 pin_change_irq_enable: enables the pin-change request
//   bit 2 timer_zero_overflow_flag: sticky, set on rollover
//   bit 1 external_pin_irq_flag: sticky, set on the chosen edge
//   bit 0 pin_change_irq_flag: sticky, set on a selected pin change
//
// 0x04 peripheral_enable_one, reset 0x00
//   bit 7 timer_one_gate_enable
//   bit 6 converter_done_enable
//   bit 2 limit_timer_match_enable
//   bit 1 timer_two_match_enable
//   bit 0 timer_one_rollover_enable
//   bits 5 to 3 are not built: writes ignored, reads zero
//
// 0x08 peripheral_enable_two, reset 0x00
//   bit 5 second_comparator_enable
//   bit 4 first_comparator_enable
//   bit 2 output_generator_shutdown_enable
//   bit 0 capture_compare_enable
//   bits 7, 6, 3 and 1 are not built: writes ignored, reads zero
//
// 0x0c peripheral_request_one: flags paired with enable one
//   Same built positions as enable one; events set, software clears
//
// 0x10 peripheral_request_two: flags paired with enable two
//   Same built positions as enable two; events set, software clears
//
// 0x14 edge select, reset 1
//   bit 0: one picks rising edges, zero picks falling edges
//
// 0x18 pin_change_select, reset 0
//   One bit per monitored port pin, PIN_COUNT bits wide
//
// 0x1c status, read only
//   bit 0 mirrors the registered core request
//   bit 1 shows any enabled peripheral pair pending, before the gates
//
// Bus timing: every access takes one wait cycle. The request edge
// raises the acknowledge; the next edge completes the access, so a
// write lands there and read data captured in the wait cycle stands.
// Read data is held until the next read begins.
//
// Flag hazard: a hardware set in the same cycle as a software write of
// zero wins, so an event is never lost to a clear that races it.
// Software may also set a flag by writing one, which is useful to
// raise a test request without the surrounding peripheral.
//
// Request timing: the core request is registered, so it follows the
// flags, enables and gates with one cycle of delay. Clearing a gate
// therefore drops the request one edge after the write lands.

module iec_interrupt_enable_control #(
  parameter int PIN_COUNT = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire iec_pkg::iec_bus_req_type bus_req,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  input wire iec_pkg::iec_events_type events,
  input wire logic external_interrupt_pin,
  input wire logic [PIN_COUNT-1:0] port_pins,
  output logic core_irq_request
);

  // Elaboration check on the pin count
  if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : g_bad_pins
    $error("PIN_COUNT must lie between 1 and 8");
  end

  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] enable_one_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] request_one_reg;
  logic [7:0] request_one_next;
  logic [7:0] request_two_reg;
  logic [7:0] request_two_next;
  logic edge_select_reg;
  logic [PIN_COUNT-1:0] pin_select_reg;
  logic ext_prev_reg;
  logic [PIN_COUNT-1:0] pins_prev_reg;
  logic primed_reg;
  logic irq_reg;
  logic bus_active;
  logic write_fire;
  logic ext_edge;
  logic [PIN_COUNT-1:0] pin_changed;
  logic pin_change_event;
  logic [7:0] set_control;
  logic periph_pending;
  logic core_pending;
  logic irq_next;
  logic [7:0] wbyte;

  assign wbyte = bus_req.writedata[7:0];

  // Every access waits one cycle; the answer edge is the one after the first
  assign bus_active = bus_req.read | bus_req.write;
  assign avs_waitrequest = bus_active & ~ack_reg;
  assign write_fire = bus_req.write & ack_reg;
  assign avs_readdata = readdata_reg;
  assign core_irq_request = irq_reg;

  // Wait-state toggle: high for the cycle in which the answer is given
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_active & ~ack_reg;
    end
  end

  // First cycle after reset has no valid previous pin level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
    end
  end

  // Previous pin levels for edge and change detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_reg <= 1'b0;
      pins_prev_reg <= '0;
    end else begin
      ext_prev_reg <= external_interrupt_pin;
      pins_prev_reg <= port_pins;
    end
  end

  // Edge on the external pin in the chosen direction
  always_comb begin
    if (edge_select_reg) begin
      ext_edge = primed_reg & external_interrupt_pin & ~ext_prev_reg;
    end else begin
      ext_edge = primed_reg & ~external_interrupt_pin & ext_prev_reg;
    end
  end

  // Change detection on each selected port pin
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin_change
    assign pin_changed[i] = primed_reg & pin_select_reg[i]
      & (port_pins[i] ^ pins_prev_reg[i]);
  end
  assign pin_change_event = |pin_changed;

  // Core flag set terms, independent of any enable
  always_comb begin
    set_control = 8'h00;
    set_control[iec_pkg::CTL_T0_FLAG] = events.timer_zero_rollover;
    set_control[iec_pkg::CTL_EXT_FLAG] = ext_edge;
    set_control[iec_pkg::CTL_PIN_FLAG] = pin_change_event;
  end

  // Control next value: a hardware set wins over a software clear
  always_comb begin
    if (write_fire && bus_req.address == iec_pkg::ADDR_CONTROL) begin
      control_next = wbyte | set_control;
    end else begin
      control_next = control_reg | set_control;
    end
  end

  // Request flags: software writes, events set, unimplemented bits stay zero
  always_comb begin
    request_one_next = request_one_reg;
    request_two_next = request_two_reg;
    if (write_fire && bus_req.address == iec_pkg::ADDR_REQUEST_ONE) begin
      request_one_next = wbyte;
    end
    if (write_fire && bus_req.address == iec_pkg::ADDR_REQUEST_TWO) begin
      request_two_next = wbyte;
    end
    request_one_next = (request_one_next | events.request_one_set)
      & iec_pkg::MASK_ONE;
    request_two_next = (request_two_next | events.request_two_set)
      & iec_pkg::MASK_TWO;
  end

  // Flag registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_reg <= iec_pkg::RESET_CONTROL;
      request_one_reg <= iec_pkg::RESET_REQUEST;
      request_two_reg <= iec_pkg::RESET_REQUEST;
    end else begin
      control_reg <= control_next;
      request_one_reg <= request_one_next;
      request_two_reg <= request_two_next;
    end
  end

  // Enable and configuration registers written by software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_one_reg <= iec_pkg::RESET_ENABLE;
      enable_two_reg <= iec_pkg::RESET_ENABLE;
      edge_select_reg <= iec_pkg::RESET_EDGE_SELECT;
      pin_select_reg <= '0;
    end else if (write_fire) begin
      if (bus_req.address == iec_pkg::ADDR_ENABLE_ONE) begin
        enable_one_reg <= wbyte & iec_pkg::MASK_ONE;
      end else if (bus_req.address == iec_pkg::ADDR_ENABLE_TWO) begin
        enable_two_reg <= wbyte & iec_pkg::MASK_TWO;
      end else if (bus_req.address == iec_pkg::ADDR_EDGE_SELECT) begin
        edge_select_reg <= wbyte[0];
      end else if (bus_req.address == iec_pkg::ADDR_PIN_SELECT) begin
        pin_select_reg <= wbyte[PIN_COUNT-1:0];
      end
    end
  end

  // Peripheral enable-flag pairs, bit by bit in matching positions
  always_comb begin
    periph_pending =
      (enable_one_reg[iec_pkg::P1_TIMER_ONE_GATE]
        & request_one_reg[iec_pkg::P1_TIMER_ONE_GATE])
      | (enable_one_reg[iec_pkg::P1_CONVERTER_DONE]
        & request_one_reg[iec_pkg::P1_CONVERTER_DONE])
      | (enable_one_reg[iec_pkg::P1_LIMIT_TIMER]
        & request_one_reg[iec_pkg::P1_LIMIT_TIMER])
      | (enable_one_reg[iec_pkg::P1_TIMER_TWO]
        & request_one_reg[iec_pkg::P1_TIMER_TWO])
      | (enable_one_reg[iec_pkg::P1_TIMER_ONE_ROLL]
        & request_one_reg[iec_pkg::P1_TIMER_ONE_ROLL])
      | (enable_two_reg[iec_pkg::P2_SECOND_COMP]
        & request_two_reg[iec_pkg::P2_SECOND_COMP])
      | (enable_two_reg[iec_pkg::P2_FIRST_COMP]
        & request_two_reg[iec_pkg::P2_FIRST_COMP])
      | (enable_two_reg[iec_pkg::P2_OUTPUT_GEN]
        & request_two_reg[iec_pkg::P2_OUTPUT_GEN])
      | (enable_two_reg[iec_pkg::P2_CAPTURE]
        & request_two_reg[iec_pkg::P2_CAPTURE]);
  end

  // Core enable-flag pairs
  always_comb begin
    core_pending =
      (control_reg[iec_pkg::CTL_T0_ENABLE]
        & control_reg[iec_pkg::CTL_T0_FLAG])
      | (control_reg[iec_pkg::CTL_EXT_ENABLE]
        & control_reg[iec_pkg::CTL_EXT_FLAG])
      | (control_reg[iec_pkg::CTL_PIN_ENABLE]
        & control_reg[iec_pkg::CTL_PIN_FLAG]);
  end

  // Combined request: global gate over core pairs and gated peripherals
  always_comb begin
    irq_next = control_reg[iec_pkg::CTL_GLOBAL_GATE]
      & (core_pending
        | (control_reg[iec_pkg::CTL_PERIPH_GATE] & periph_pending));
  end

  // Registered request towards the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Read data captured in the wait cycle, zero for unmapped addresses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_reg <= 32'h0000_0000;
    end else if (bus_req.read && !ack_reg) begin
      readdata_reg <= 32'h0000_0000;
      if (bus_req.address == iec_pkg::ADDR_CONTROL) begin
        readdata_reg[7:0] <= control_reg;
      end else if (bus_req.address == iec_pkg::ADDR_ENABLE_ONE) begin
        readdata_reg[7:0] <= enable_one_reg;
      end else if (bus_req.address == iec_pkg::ADDR_ENABLE_TWO) begin
        readdata_reg[7:0] <= enable_two_reg;
      end else if (bus_req.address == iec_pkg::ADDR_REQUEST_ONE) begin
        readdata_reg[7:0] <= request_one_reg;
      end else if (bus_req.address == iec_pkg::ADDR_REQUEST_TWO) begin
        readdata_reg[7:0] <= request_two_reg;
      end else if (bus_req.address == iec_pkg::ADDR_EDGE_SELECT) begin
        readdata_reg[0] <= edge_select_reg;
      end else if (bus_req.address == iec_pkg::ADDR_PIN_SELECT) begin
        readdata_reg[PIN_COUNT-1:0] <= pin_select_reg;
      end else if (bus_req.address == iec_pkg::ADDR_STATUS) begin
        readdata_reg[iec_pkg::STS_CORE_IRQ] <= irq_reg;
        readdata_reg[iec_pkg::STS_PERIPH_PENDING] <= periph_pending;
      end
    end
  end

endmodule : iec_interrupt_enable_control

`default_nettype wire

// file: rtl/iec_pkg.sv
// Package of register map, field positions and bus types for the block
package iec_pkg;
  // Register byte addresses on the 32-bit bus
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_ENABLE_ONE = 5'h04;
  localparam logic [4:0] ADDR_ENABLE_TWO = 5'h08;
  localparam logic [4:0] ADDR_REQUEST_ONE = 5'h0c;
  localparam logic [4:0] ADDR_REQUEST_TWO = 5'h10;
  localparam logic [4:0] ADDR_EDGE_SELECT = 5'h14;
  localparam logic [4:0] ADDR_PIN_SELECT = 5'h18;
  localparam logic [4:0] ADDR_STATUS = 5'h1c;

  // Field positions of interrupt_control
  localparam int CTL_GLOBAL_GATE = 7;
  localparam int CTL_PERIPH_GATE = 6;
  localparam int CTL_T0_ENABLE = 5;
  localparam int CTL_EXT_ENABLE = 4;
  localparam int CTL_PIN_ENABLE = 3;
  localparam int CTL_T0_FLAG = 2;
  localparam int CTL_EXT_FLAG = 1;
  localparam int CTL_PIN_FLAG = 0;

  // Field positions of peripheral_enable_one and peripheral_request_one
  localparam int P1_TIMER_ONE_GATE = 7;
  localparam int P1_CONVERTER_DONE = 6;
  localparam int P1_LIMIT_TIMER = 2;
  localparam int P1_TIMER_TWO = 1;
  localparam int P1_TIMER_ONE_ROLL = 0;

  // Field positions of peripheral_enable_two and peripheral_request_two
  localparam int P2_SECOND_COMP = 5;
  localparam int P2_FIRST_COMP = 4;
  localparam int P2_OUTPUT_GEN = 2;
  localparam int P2_CAPTURE = 0;

  // Implemented bits, everything else reads as zero
  localparam logic [7:0] MASK_ONE = 8'hc7;
  localparam logic [7:0] MASK_TWO = 8'h35;

  // Reset values
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_REQUEST = 8'h00;
  localparam logic RESET_EDGE_SELECT = 1'b1;

  // Status register fields
  localparam int STS_CORE_IRQ = 0;
  localparam int STS_PERIPH_PENDING = 1;

  // Event pulses from the surrounding peripherals
  typedef struct packed {
    logic timer_zero_rollover;
    logic [7:0] request_one_set;
    logic [7:0] request_two_set;
  } iec_events_type;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } iec_bus_req_type;
endpackage : iec_pkg

// file: sim/iec_properties.sv
// Port-level concurrent checks for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module iec_properties #(
  parameter int PIN_COUNT = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire iec_pkg::iec_bus_req_type bus_req,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire iec_pkg::iec_events_type events,
  input wire logic external_interrupt_pin,
  input wire logic [PIN_COUNT-1:0] port_pins,
  input wire logic core_irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic req;
  logic done;
  logic gate_reg;
  // Request pending and request completing this cycle
  assign req = bus_req.read | bus_req.write;
  assign done = req & ~avs_waitrequest;
  // Shadow of the global gate, taken from completed control writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_reg <= 1'b0;
    end else if (bus_req.write && done &&
                 bus_req.address == iec_pkg::ADDR_CONTROL) begin
      gate_reg <= bus_req.writedata[iec_pkg::CTL_GLOBAL_GATE];
    end
  end
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("request answered without a wait cycle");
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised while idle");
  chk_data_upper: assert property (bus_req.read && done |->
    avs_readdata[31:8] == 24'h0) else $error("upper read bits not zero");
  chk_mask_one: assert property (bus_req.read && done && bus_req.address ==
    iec_pkg::ADDR_ENABLE_ONE |-> (avs_readdata[7:0] & ~iec_pkg::MASK_ONE)
    == 8'h00) else $error("unimplemented enable one bit set");
  chk_mask_two: assert property (bus_req.read && done && bus_req.address ==
    iec_pkg::ADDR_REQUEST_TWO |-> (avs_readdata[7:0] & ~iec_pkg::MASK_TWO)
    == 8'h00) else $error("unimplemented request two bit set");
  chk_data_hold: assert property (!(bus_req.read && avs_waitrequest) |=>
    $stable(avs_readdata)) else $error("read data changed outside a read");
  chk_gate_block: assert property (!gate_reg |=> !core_irq_request)
    else $error("request with global gate clear");
  chk_irq_gated: assert property (core_irq_request |-> $past(gate_reg))
    else $error("request without prior global gate");
endmodule : iec_properties
bind iec_interrupt_enable_control iec_properties #(.PIN_COUNT(PIN_COUNT))
  i_iec_properties (.clk(clk), .rstn(rstn), .bus_req(bus_req),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .events(events), .external_interrupt_pin(external_interrupt_pin),
  .port_pins(port_pins), .core_irq_request(core_irq_request));
`default_nettype wire

// file: sim/tb.sv
// Register-level testbench for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic clk;
  logic rstn;
  iec_pkg::iec_bus_req_type bus_req;
  logic avs_waitrequest;
  logic [31:0] avs_readdata;
  iec_pkg::iec_events_type events;
  logic ext_pin;
  logic [5:0] port_pins;
  logic core_irq_request;
  int mismatches = 0;
  int cmp_count = 0;
  iec_interrupt_enable_control #(.PIN_COUNT(6)) i_iec_interrupt_enable_control (
    .clk(clk), .rstn(rstn), .bus_req(bus_req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .events(events), .external_interrupt_pin(ext_pin),
    .port_pins(port_pins), .core_irq_request(core_irq_request));
  // Clock of 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [4:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    bus_req <= '{read: ~wr, write: wr, address: a, writedata: {24'h0, d}};
    // Hold the request until waitrequest is sampled low at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    q = avs_readdata[7:0];
    bus_req <= '0;
  endtask : acc
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask : rd_chk
  task automatic pulse(input iec_pkg::iec_events_type e);
    @(posedge clk);
    events <= e;
    @(posedge clk);
    events <= '0;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  // Main sequence
  initial begin
    iec_pkg::iec_events_type e;
    logic [7:0] m;
    logic [7:0] b;
    logic [4:0] en;
    logic [4:0] rq;
    rstn = 1'b0;
    bus_req = '0;
    events = '0;
    ext_pin = 1'b0;
    port_pins = 6'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_chk(5'(a * 4), (a == 5) ? 8'h01 : 8'h00);
    end
    wr(iec_pkg::ADDR_ENABLE_ONE, 8'hff);
    rd_chk(iec_pkg::ADDR_ENABLE_ONE, 8'hc7);
    wr(iec_pkg::ADDR_ENABLE_TWO, 8'hff);
    rd_chk(iec_pkg::ADDR_ENABLE_TWO, 8'h35);
    $display("test reset and masks done");
    for (int r = 0; r < 2; r++) begin
      m = r ? iec_pkg::MASK_TWO : iec_pkg::MASK_ONE;
      en = r ? iec_pkg::ADDR_ENABLE_TWO : iec_pkg::ADDR_ENABLE_ONE;
      rq = r ? iec_pkg::ADDR_REQUEST_TWO : iec_pkg::ADDR_REQUEST_ONE;
      for (int i = 0; i < 8; i++) begin
        b = 8'h01 << i;
        if (m[i]) begin
          e = '0;
          e.request_one_set = r ? 8'h00 : b;
          e.request_two_set = r ? b : 8'h00;
          wr(iec_pkg::ADDR_CONTROL, 8'hc0);
          wr(en, ~b);
          pulse(e);
          settle(1);
          `CHK(core_irq_request, 1'b0)
          wr(en, b);
          settle(1);
          `CHK(core_irq_request, 1'b1)
          wr(iec_pkg::ADDR_CONTROL, 8'h80);
          settle(1);
          `CHK(core_irq_request, 1'b0)
          rd_chk(rq, b);
          wr(rq, 8'h00);
        end
      end
    end
    $display("test peripheral gating done");
    wr(iec_pkg::ADDR_CONTROL, 8'h00);
    e = '0;
    e.timer_zero_rollover = 1'b1;
    pulse(e);
    rd_chk(iec_pkg::ADDR_CONTROL, 8'h04);
    wr(iec_pkg::ADDR_CONTROL, 8'ha4);
    settle(1);
    `CHK(core_irq_request, 1'b1)
    wr(iec_pkg::ADDR_CONTROL, 8'h24);
    settle(1);
    `CHK(core_irq_request, 1'b0)
    rd_chk(iec_pkg::ADDR_CONTROL, 8'h24);
    wr(iec_pkg::ADDR_CONTROL, 8'h20);
    rd_chk(iec_pkg::ADDR_CONTROL, 8'h20);
    $display("test timer zero done");
    for (int s = 1; s >= 0; s--) begin
      wr(iec_pkg::ADDR_EDGE_SELECT, 8'(s));
      for (int k = 0; k < 2; k++) begin
        wr(iec_pkg::ADDR_CONTROL, 8'h90);
        @(posedge clk);
        ext_pin <= ~ext_pin;
        settle(2);
        `CHK(core_irq_request, (ext_pin == s[0]))
        rd_chk(iec_pkg::ADDR_CONTROL, (ext_pin == s[0]) ? 8'h92 : 8'h90);
      end
    end
    $display("test external pin done");
    wr(iec_pkg::ADDR_PIN_SELECT, 8'h01);
    wr(iec_pkg::ADDR_CONTROL, 8'h88);
    @(posedge clk);
    port_pins <= 6'h02;
    settle(2);
    `CHK(core_irq_request, 1'b0)
    @(posedge clk);
    port_pins <= 6'h03;
    settle(2);
    `CHK(core_irq_request, 1'b1)
    rd_chk(iec_pkg::ADDR_CONTROL, 8'h89);
    $display("test pin change done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
